//--- rtl/pmcap_regs.sv
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module pmcap_regs
  import pmcap_pkg::*;
#(
  parameter int         ADR_W          = 8,
  parameter int         DEV_RST_CYCLES = PMCAP_DEV_RST_CYC,
  parameter logic [2:0] AUX_CURRENT    = 3'h0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             por_i,
  input  wire logic             ce_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             wake_detect_i,
  output logic      [1:0]       power_state_o,
  output logic                  dev_reset_o,
  output logic                  wake_event_out_n_o,
  output logic                  irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (ADR_W < 8 || ADR_W > 32) begin : g_bad_adr
    $error("ADR_W must lie between 8 and 32");
  end
  if (DEV_RST_CYCLES < 1 || DEV_RST_CYCLES > 255) begin : g_bad_rst
    $error("DEV_RST_CYCLES must lie between 1 and 255");
  end

  localparam logic [7:0] RST_LOAD = 8'(DEV_RST_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                   ack_q;
  logic [31:0]            dat_q;
  logic [1:0]             ps_q;
  logic                   wake_en_q;
  logic                   wake_sts_q;
  logic                   wake_sts_d;
  logic [PMCAP_IRQ_W-1:0] irq_sts_q;
  logic [PMCAP_IRQ_W-1:0] irq_sts_d;
  logic [PMCAP_IRQ_W-1:0] irq_msk_q;
  logic [PMCAP_IRQ_W-1:0] irq_evt_w;
  pmcap_rst_st_t          rs_q;
  pmcap_rst_st_t          rs_d;
  logic [7:0]             rcnt_q;
  logic [7:0]             rcnt_d;
  logic                   rst_any_w;
  logic                   req_w;
  logic                   commit_w;
  logic                   wr_w;
  logic                   hi_zero_w;
  logic                   hit_cap_w;
  logic                   hit_csr_w;
  logic                   hit_sts_w;
  logic                   hit_msk_w;
  logic                   csr_wr_lo_w;
  logic                   csr_wr_hi_w;
  logic                   sts_wr_w;
  logic                   msk_wr_w;
  logic                   ps_legal_w;
  logic                   ps_load_w;
  logic                   d3_exit_w;
  logic                   wake_clr_w;
  pmcap_cap_t             cap_w;
  pmcap_csr_t             csr_w;
  logic [31:0]            rd_w;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Sticky bits answer only to por_i; everything else also to rst_i
  assign rst_any_w   = rst_i | por_i;
  assign req_w       = wb_cyc_i & wb_stb_i & ~ack_q;
  // Writes land on the ack edge, the one the master samples
  assign commit_w    = wb_cyc_i & wb_stb_i & ack_q;
  assign wr_w        = commit_w & wb_we_i;
  assign hi_zero_w   = (wb_adr_i >> 8) == '0;
  assign hit_cap_w   = hi_zero_w & (wb_adr_i[7:2] == PMCAP_OFF_CAP[7:2]);
  assign hit_csr_w   = hi_zero_w & (wb_adr_i[7:2] == PMCAP_OFF_CSR[7:2]);
  assign hit_sts_w   = hi_zero_w & (wb_adr_i[7:2] == PMCAP_OFF_IRQ_STS[7:2]);
  assign hit_msk_w   = hi_zero_w & (wb_adr_i[7:2] == PMCAP_OFF_IRQ_MSK[7:2]);
  assign csr_wr_lo_w = wr_w & hit_csr_w & wb_sel_i[0];
  assign csr_wr_hi_w = wr_w & hit_csr_w & wb_sel_i[1];
  assign sts_wr_w    = wr_w & hit_sts_w & wb_sel_i[0];
  assign msk_wr_w    = wr_w & hit_msk_w & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_any_w) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_any_w) begin
      dat_q <= 32'h0000_0000;
    end else if (ce_i && req_w) begin
      dat_q <= rd_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power state
  // drop illegal codes
  assign ps_legal_w = (wb_dat_i[1:0] == PMCAP_PS_D0) |
                      (wb_dat_i[1:0] == PMCAP_PS_D3);
  assign ps_load_w  = csr_wr_lo_w & ps_legal_w;
  assign d3_exit_w  = ps_load_w & (ps_q == PMCAP_PS_D3) &
                      (wb_dat_i[1:0] == PMCAP_PS_D0);

  always_ff @(posedge clk_i) begin
    if (rst_any_w) begin
      ps_q <= PMCAP_PS_D0;
    end else if (ce_i && ps_load_w) begin
      ps_q <= wb_dat_i[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Internal reset sequencer
  // internal pulse only, no bus reset pin is driven
  always_comb begin
    rs_d   = rs_q;
    rcnt_d = rcnt_q;
    unique case (rs_q)
      PMCAP_RS_IDLE: begin
        if (d3_exit_w) begin
          rs_d   = PMCAP_RS_BUSY;
          rcnt_d = RST_LOAD;
        end
      end
      PMCAP_RS_BUSY: begin
        if (rcnt_q == 8'h00) begin
          rs_d = PMCAP_RS_IDLE;
        end else begin
          rcnt_d = rcnt_q - 8'h01;
        end
      end
      default: begin
        rs_d = PMCAP_RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_any_w) begin
      rs_q   <= PMCAP_RS_IDLE;
      rcnt_q <= 8'h00;
    end else if (ce_i) begin
      rs_q   <= rs_d;
      rcnt_q <= rcnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky wake bits
  // set wins over a same-cycle clear
  assign wake_clr_w = csr_wr_hi_w & wb_dat_i[15];
  assign wake_sts_d = wake_detect_i | (wake_sts_q & ~wake_clr_w);

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      wake_en_q <= PMCAP_WAKE_EN_RST;
    end else if (ce_i && csr_wr_hi_w) begin
      wake_en_q <= wb_dat_i[8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      wake_sts_q <= PMCAP_WAKE_ST_RST;
    end else if (ce_i) begin
      wake_sts_q <= wake_sts_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  assign irq_evt_w[PMCAP_IRQ_WAKE] = wake_detect_i;
  assign irq_evt_w[PMCAP_IRQ_D3X]  = d3_exit_w;
  // Event beats a clear in the same cycle
  assign irq_sts_d = irq_evt_w |
                     (irq_sts_q & ~(wb_dat_i[PMCAP_IRQ_W-1:0] &
                                    {PMCAP_IRQ_W{sts_wr_w}}));

  always_ff @(posedge clk_i) begin
    if (rst_any_w) begin
      irq_sts_q <= PMCAP_IRQ_RST;
      irq_msk_q <= PMCAP_IRQ_RST;
    end else if (ce_i) begin
      irq_sts_q <= irq_sts_d;
      if (msk_wr_w) begin
        irq_msk_q <= wb_dat_i[PMCAP_IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  // identifier byte
  assign cap_w.cap_id    = PMCAP_CAP_ID;
  assign cap_w.next_ptr  = PMCAP_NEXT_PTR;
  assign cap_w.version   = PMCAP_VERSION;
  assign cap_w.clk_req   = 1'b0;
  assign cap_w.rsvd20    = 1'b0;
  assign cap_w.dsi       = 1'b0;
  assign cap_w.aux_cur   = AUX_CURRENT;
  assign cap_w.d1_supp   = 1'b0;
  assign cap_w.d2_supp   = 1'b0;
  assign cap_w.wake_supp = PMCAP_WAKE_SUPP;

  assign csr_w.wake_sts   = wake_sts_q;
  assign csr_w.data_scale = 2'h0;
  assign csr_w.data_sel   = 4'h0;
  assign csr_w.wake_en    = wake_en_q;
  assign csr_w.rsvd       = 6'h00;
  assign csr_w.pstate     = ps_q;

  // Unmapped words read zero and still get an ack
  assign rd_w = hit_cap_w ? cap_w :
                hit_csr_w ? {16'h0000, csr_w} :
                hit_sts_w ? {{(32-PMCAP_IRQ_W){1'b0}}, irq_sts_q} :
                hit_msk_w ? {{(32-PMCAP_IRQ_W){1'b0}}, irq_msk_q} :
                32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = dat_q;
  assign power_state_o = ps_q;
  assign dev_reset_o   = (rs_q == PMCAP_RS_BUSY);
  assign wake_event_out_n_o = ~(wake_sts_q & wake_en_q);
  assign irq_o         = |(irq_sts_q & irq_msk_q);

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [8:0] hi_cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_any_w || !dev_reset_o) begin
      hi_cnt_q <= 9'h000;
    end else if (ce_i) begin
      hi_cnt_q <= hi_cnt_q + 9'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);

  chk_ps_legal: assert property (
    power_state_o == PMCAP_PS_D0 || power_state_o == PMCAP_PS_D3)
    else $error("power state holds an illegal code");

  chk_ps_discard: assert property (
    ce_i && csr_wr_lo_w && !ps_legal_w |=> $stable(power_state_o))
    else $error("illegal power state write was taken");

  chk_d3_exit_pulse: assert property (
    ce_i && d3_exit_w |=> dev_reset_o && power_state_o == PMCAP_PS_D0)
    else $error("D3 exit did not start the internal reset");

  // A pulse cut short by a reset is not a length error
  chk_rst_length: assert property (
    $fell(dev_reset_o) && !$past(rst_any_w) |->
      hi_cnt_q == 9'(DEV_RST_CYCLES))
    else $error("internal reset pulse has the wrong length");

  // Only a bus write may change wake_en_q or clear wake_sts_q while rst_i is high
  chk_en_sticky: assert property (
    @(posedge clk_i) disable iff (por_i)
    rst_i && !wr_w |=> $stable(wake_en_q) &&
                       (wake_sts_q || !$past(wake_sts_q)))
    else $error("sticky bit lost across ordinary reset");

  chk_wake_pin: assert property (
    !wake_event_out_n_o |-> $past(wake_en_q) || wake_en_q)
    else $error("wake pin asserted while disabled");

  chk_cap_ident: assert property (
    wb_ack_o && hit_cap_w |-> wb_dat_o[15:0] == 16'ha801)
    else $error("capability id or pointer reads wrong");

  chk_cap_fields: assert property (
    wb_ack_o && hit_cap_w |->
      wb_dat_o[31:25] == 7'h64 && wb_dat_o[21:16] == 6'h03)
    else $error("capability fields read wrong");

  chk_csr_zeros: assert property (
    wb_ack_o && hit_csr_w |->
      wb_dat_o[14:9] == 6'h00 && wb_dat_o[7:2] == 6'h00 &&
      wb_dat_o[31:16] == 16'h0000)
    else $error("unimplemented control bits read nonzero");

  chk_sts_set: assert property (
    ce_i && wake_detect_i |=> wake_sts_q ##1 wake_sts_q || ce_i)
    else $error("wake event did not set status");

  chk_sts_clear: assert property (
    ce_i && wake_clr_w && !wake_detect_i |=> !wake_sts_q)
    else $error("write one did not clear wake status");

  chk_ack_drop: assert property (
    wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  cov_d3_entry: cover property (
    ce_i && ps_load_w && wb_dat_i[1:0] == PMCAP_PS_D3);

  cov_d3_exit: cover property (
    ce_i && d3_exit_w ##1 dev_reset_o);

  cov_wake_pin: cover property (
    wake_en_q && wake_detect_i ##1 !wake_event_out_n_o);

  cov_illegal_ps: cover property (
    ce_i && csr_wr_lo_w && !ps_legal_w);

  cov_sticky_keep: cover property (
    @(posedge clk_i) rst_i && !por_i && wake_en_q && wake_sts_q);

endmodule

//--- rtl/pmcap_pkg.sv
// Operation
// - A write of code 01 or 10 into the power state field is discarded and the state is kept.
// - Moving from D3 to D0 by a write pulses an internal device reset, never the bus reset pin.
// - Bit 8 is a sticky wake enable that gates the wake output, resets to 0 and survives ordinary resets.
// - Bits 7:0 of the capability word read 01h and ignore writes.
// - Bits 15:8 of the capability word read the fixed chain pointer A8h.
// - Bits 18:16 of the capability word read version 011.
// - Bit 19 reads 0 since no bus clock is needed to signal a wake event.
// - Bit 21 reads 0 since no extra initialisation follows entry to D0.
// - Bits 25 and 26 read 0 since the D1 and D2 states are not supported.
// - Bits 31:27 read 11001 to advertise wake from D0, D3 hot and D3 cold.
// - Data select bits 12:9 and data scale bits 14:13 read 0 and ignore writes.
package pmcap_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] PMCAP_OFF_CAP     = 8'h90;
  localparam logic [7:0] PMCAP_OFF_CSR     = 8'h94;
  localparam logic [7:0] PMCAP_OFF_IRQ_STS = 8'hc0;
  localparam logic [7:0] PMCAP_OFF_IRQ_MSK = 8'hc4;

  //////////////////////////////////////////////////////////////////////////////
  // Fixed field values
  localparam logic [7:0] PMCAP_CAP_ID      = 8'h01;
  localparam logic [7:0] PMCAP_NEXT_PTR    = 8'ha8;
  localparam logic [2:0] PMCAP_VERSION     = 3'h3;
  localparam logic [4:0] PMCAP_WAKE_SUPP   = 5'h19;
  localparam logic [1:0] PMCAP_PS_D0       = 2'h0;
  localparam logic [1:0] PMCAP_PS_D3       = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status layout and reset values
  localparam int         PMCAP_IRQ_W       = 2;
  localparam int         PMCAP_IRQ_WAKE    = 0;
  localparam int         PMCAP_IRQ_D3X     = 1;
  localparam logic [1:0] PMCAP_IRQ_RST     = 2'h0;
  localparam logic       PMCAP_WAKE_EN_RST = 1'b0;
  localparam logic       PMCAP_WAKE_ST_RST = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int         PMCAP_CLK_NS      = 4;
  localparam int         PMCAP_DEV_RST_NS  = 64;
  localparam int         PMCAP_DEV_RST_CYC =
    (PMCAP_DEV_RST_NS + PMCAP_CLK_NS - 1) / PMCAP_CLK_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Layouts
  typedef struct packed {
    logic [4:0] wake_supp;
    logic       d2_supp;
    logic       d1_supp;
    logic [2:0] aux_cur;
    logic       dsi;
    logic       rsvd20;
    logic       clk_req;
    logic [2:0] version;
    logic [7:0] next_ptr;
    logic [7:0] cap_id;
  } pmcap_cap_t;

  typedef struct packed {
    logic       wake_sts;
    logic [1:0] data_scale;
    logic [3:0] data_sel;
    logic       wake_en;
    logic [5:0] rsvd;
    logic [1:0] pstate;
  } pmcap_csr_t;

  typedef enum logic [1:0] {
    PMCAP_RS_IDLE = 2'b01,
    PMCAP_RS_BUSY = 2'b10
  } pmcap_rst_st_t;

endpackage

//--- tb/power_mgmt_capability_regs_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module power_mgmt_capability_regs_tb;
  import pmcap_pkg::*;
  localparam int RST_CYC = 4;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        por_i = 1;
  logic        ce_i  = 1;
  logic        cyc   = 0;
  logic        stb   = 0;
  logic        we    = 0;
  logic        wake  = 0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  wire  [31:0] rdat;
  wire         ack;
  wire  [1:0]  pstate;
  wire         dev_rst;
  wire         wake_n;
  wire         irq;
  logic [1:0]  st;
  logic        en;
  logic        sts;
  logic [31:0] w;
  logic [3:0]  s;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles    = 0;

  pmcap_regs #(.DEV_RST_CYCLES(RST_CYC)) dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .por_i              (por_i),
    .ce_i               (ce_i),
    .wb_cyc_i           (cyc),
    .wb_stb_i           (stb),
    .wb_we_i            (we),
    .wb_adr_i           (adr),
    .wb_sel_i           (sel),
    .wb_dat_i           (wdat),
    .wb_dat_o           (rdat),
    .wb_ack_o           (ack),
    .wake_detect_i      (wake),
    .power_state_o      (pstate),
    .dev_reset_o        (dev_rst),
    .wake_event_out_n_o (wake_n),
    .irq_o              (irq)
  );

  always #2 clk_i = ~clk_i;

  // Whole run needs well under this
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic we_v, input logic [7:0] a,
                     input logic [3:0] sl, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= we_v;
    adr  <= a;
    sel  <= sl;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] sl,
                    input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, sl, d, r);
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 4'hf, 32'h0, r);
    `CHK(r, e)
  endtask

  task automatic pulse(input bit which);
    @(posedge clk_i);
    if (which) por_i <= 1'b1;
    else if (!which) rst_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
    rst_i <= 1'b0;
  endtask

  task automatic wake_hit;
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
  endtask

  task automatic count_rst(input int e);
    int n;
    n = 0;
    // Pulse starts on the commit edge, so sample the current negedge too
    repeat (RST_CYC + 6) begin
      if (dev_rst !== 1'b0) n++;
      @(negedge clk_i);
    end
    `CHK(n, e)
  endtask

  function automatic logic [31:0] csr(input logic [1:0] p,
                                      input logic e, input logic t);
    return {16'h0, t, 6'h00, e, 6'h00, p};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] codes [8];
    codes = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0, 2'h3};
    void'($urandom(32'he6a6));
    repeat (2) @(posedge clk_i);
    por_i <= 1'b0;
    rst_i <= 1'b0;
    rd(PMCAP_OFF_CAP, 32'hc803a801);
    wr(PMCAP_OFF_CAP, 4'hf, $urandom);
    rd(PMCAP_OFF_CAP, 32'hc803a801);
    rd(8'h98, 32'h0);
    rd(PMCAP_OFF_CSR, 32'h0);
    $display("test capability word done");
    st = PMCAP_PS_D0;
    for (int i = 0; i < 8; i++) begin
      wr(PMCAP_OFF_CSR, 4'hf, ($urandom & 32'hffff7efc) | codes[i]);
      if (codes[i] == 2'h0 || codes[i] == 2'h3) st = codes[i];
      rd(PMCAP_OFF_CSR, csr(st, 1'b0, 1'b0));
      `CHK(pstate, st)
    end
    $display("test power state codes done");
    wr(PMCAP_OFF_IRQ_STS, 4'h1, 32'h3);
    wr(PMCAP_OFF_IRQ_MSK, 4'h1, 32'h2);
    `CHK(irq, 1'b0)
    wr(PMCAP_OFF_CSR, 4'h1, 32'h0);
    count_rst(RST_CYC);
    `CHK(irq, 1'b1)
    rd(PMCAP_OFF_IRQ_STS, 32'h2);
    wr(PMCAP_OFF_IRQ_STS, 4'h1, 32'h2);
    `CHK(irq, 1'b0)
    wr(PMCAP_OFF_CSR, 4'h1, 32'h0);
    count_rst(0);
    $display("test device reset done");
    wake_hit();
    @(negedge clk_i);
    `CHK(wake_n, 1'b1)
    rd(PMCAP_OFF_CSR, csr(2'h0, 1'b0, 1'b1));
    wr(PMCAP_OFF_CSR, 4'h2, 32'h100);
    `CHK(wake_n, 1'b0)
    pulse(1'b0);
    rd(PMCAP_OFF_CSR, csr(2'h0, 1'b1, 1'b1));
    wr(PMCAP_OFF_CSR, 4'h2, 32'h100);
    rd(PMCAP_OFF_CSR, csr(2'h0, 1'b1, 1'b1));
    wr(PMCAP_OFF_CSR, 4'h2, 32'h8100);
    rd(PMCAP_OFF_CSR, csr(2'h0, 1'b1, 1'b0));
    `CHK(wake_n, 1'b1)
    pulse(1'b1);
    rd(PMCAP_OFF_CSR, 32'h0);
    // Clock enable low: a wake pulse must not be taken
    ce_i <= 1'b0;
    wake_hit();
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(PMCAP_OFF_CSR, 32'h0);
    rd(PMCAP_OFF_IRQ_STS, 32'h0);
    $display("test wake bits done");
    st  = 2'h0;
    en  = 1'b0;
    sts = 1'b0;
    for (int i = 0; i < 24; i++) begin
      w = $urandom;
      s = 4'($urandom);
      if (w[20]) begin
        wake_hit();
        sts = 1'b1;
      end
      wr(PMCAP_OFF_CSR, s, w);
      if (s[0] && (w[1:0] == 2'h0 || w[1:0] == 2'h3)) st = w[1:0];
      if (s[1]) begin
        en = w[8];
        if (w[15]) sts = 1'b0;
      end
      rd(PMCAP_OFF_CSR, csr(st, en, sts));
      `CHK(pstate, st)
      `CHK(wake_n, ~(en & sts))
      `CHK(irq, 1'b0)
    end
    $display("test random writes done");
    complete_run();
  end
endmodule
